// *** logic/omp_pkg.sv ***
// Constants, register map and helpers of the output mixer and PWM modulator.
package omp_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OMP_FSC_ADDR = 8'h03;
	localparam logic [7:0] OMP_LIM_ADDR = 8'h04;
	localparam logic [7:0] OMP_CFG_ADDR = 8'h05;
	localparam logic [7:0] OMP_SVL_ADDR = 8'h06;
	localparam logic [7:0] OMP_AMT_ADDR = 8'h07;
	localparam logic [2:0] OMP_MIX_PAGE = 3'h1;
	localparam logic [7:0] OMP_FSC_RST = 8'h80;
	localparam logic [2:0] OMP_LIM_RST = 3'h5;
	localparam logic [7:0] OMP_CFG_RST = 8'h00;
	localparam logic [7:0] OMP_SVL_RST = 8'h00;
	localparam logic [7:0] OMP_AMT_RST = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int OMP_HPF_BIT = 7;
	localparam int OMP_DE_LSB = 0;
	localparam int OMP_CFG_PASS = 0;
	localparam int OMP_CFG_SIX = 1;
	localparam int OMP_CFG_SE = 2;
	localparam int OMP_CFG_SVC = 3;
	localparam int OMP_CFG_RNG = 4;
	localparam int OMP_CFG_AM = 6;
	localparam int OMP_CFG_LO = 7;

	// ----------------------------------------------------------------
	// Arithmetic constants
	// ----------------------------------------------------------------
	localparam logic [4:0] OMP_MIX_UNITY = 5'h10;
	localparam int OMP_MIX_FRAC = 4;
	localparam int OMP_HPF_SHIFT = 13;
	localparam int OMP_DE_SHELF = 2;
	localparam logic [2:0] OMP_DE_K32 = 3'h2;
	localparam logic [2:0] OMP_DE_K44 = 3'h3;
	localparam logic [2:0] OMP_DE_K48 = 3'h3;
	localparam logic [3:0] OMP_OSR_LO = 4'h8;
	localparam logic [3:0] OMP_OSR_MID = 4'h4;
	localparam logic [3:0] OMP_OSR_HI = 4'h2;
	localparam logic [7:0] OMP_LIM_BASE = 8'hf0;

	typedef logic [7:0][2:0][7:0] omp_mix_t;

	// Reset mixer: output n takes channel n at unity gain.
	function automatic omp_mix_t omp_mix_rst();
		omp_mix_t m;
		m = '0;
		for (int o = 0; o < 8; o++) begin
			m[o][0] = {3'(o), OMP_MIX_UNITY};
		end
		return m;
	endfunction

	// Saturate a wide signed value to a 32-bit sample.
	function automatic logic [31:0] omp_sat(logic signed [39:0] v);
		if (v > 40'sh007fffffff) begin
			return 32'h7fffffff;
		end
		if (v < -40'sh0080000000) begin
			return 32'h80000000;
		end
		return v[31:0];
	endfunction

	// Oversampling ratio per detected rate code.
	function automatic logic [3:0] omp_osr(logic [2:0] c);
		if (c < 3'h4) begin
			return OMP_OSR_LO;
		end
		return (c < 3'h6) ? OMP_OSR_MID : OMP_OSR_HI;
	endfunction

	// De-emphasis pole shift per selected rate.
	function automatic logic [2:0] omp_de_shift(logic [1:0] c);
		return (c == 2'h1) ? OMP_DE_K32 : ((c == 2'h2) ? OMP_DE_K44 : OMP_DE_K48);
	endfunction

endpackage

// *** logic/omp_chan_mod.sv ***
// One channel: fifth-order noise shaper and pulse-width modulator.
`timescale 1ns/1ps
`default_nettype none
module omp_chan_mod import omp_pkg::*; #(
	parameter int IN_W = 16,
	parameter int CNT_W = 8
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic [IN_W-1:0] sample_i,
	input wire logic [CNT_W-1:0] lim_i,
	input wire logic [CNT_W-1:0] cnt_i,
	input wire logic [CNT_W-1:0] last_i,
	input wire logic se_i,
	output logic p_o,
	output logic m_o
);

	// ----------------------------------------------------------------
	// Noise shaper
	// ----------------------------------------------------------------
	logic [4:0][11:0] e_r;
	logic [4:0][11:0] e_nxt;
	logic [CNT_W-1:0] duty_r;
	logic [CNT_W-1:0] duty_nxt;
	logic p_nxt;
	logic m_nxt;
	logic signed [19:0] v;
	logic signed [19:0] qv;
	logic signed [19:0] er;
	logic signed [9:0] qmax;
	logic signed [9:0] q;
	logic signed [19:0] ex [5];

	// Error feedback with (1 - z^-1)^5 shaping, clamped to the modulation limit.
	always_comb begin
		for (int k = 0; k < 5; k++) begin
			ex[k] = 20'(signed'(e_r[k]));
		end
		v = 20'(signed'(sample_i)) + 20'sd5 * ex[0] - 20'sd10 * ex[1]
			+ 20'sd10 * ex[2] - 20'sd5 * ex[3] + ex[4];
		qv = v >>> 8;
		qmax = 10'(lim_i) - 10'sd128;
		if (qv > 20'(qmax)) begin
			q = qmax;
		end else if (qv < -20'(qmax)) begin
			q = -qmax;
		end else begin
			q = qv[9:0];
		end
		er = v - (20'(q) <<< 8);
		e_nxt = e_r;
		duty_nxt = duty_r;
		if (tick_i) begin
			e_nxt = {e_r[3:0], (er > 20'sd2047) ? 12'h7ff
				: ((er < -20'sd2048) ? 12'h800 : er[11:0])};
			duty_nxt = CNT_W'(10'sd128 + q);
		end
		p_nxt = cnt_i < duty_r;
		// Bridge loads get a mirrored pulse, single-ended loads the complement.
		m_nxt = se_i ? !p_nxt : ((last_i - cnt_i) < duty_r);
	end

	// Shaper state and output flops.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			e_r <= '0;
			duty_r <= CNT_W'(128);
			p_o <= 1'b0;
			m_o <= 1'b0;
		end else begin
			e_r <= e_nxt;
			duty_r <= duty_nxt;
			p_o <= p_nxt;
			m_o <= m_nxt;
		end
	end

	// Duty stays inside the programmed modulation limit on both sides.
	property p_duty_lim;
		@(posedge ref_clk_i) disable iff (rst_i)
		tick_i |=> (duty_r <= $past(lim_i))
			&& ({1'b0, duty_r} + {1'b0, $past(lim_i)} >= 9'h100);
	endproperty
	a_duty_lim: assert property (p_duty_lim) else $error("duty beyond limit");

endmodule
`default_nettype wire

// *** logic/omp_core.sv ***
// Output crossbar mixers, per-channel filters and eight PWM modulators.
// Function
// - Per-output crossbar: two sources, three on 7-8.
// - Mixer gains writable through the control port.
// - Pass-through maps channel n to output n.
// - Accept 32-bit samples, drive eight PWM channels.
// - Eight power drives, or six plus line-out.
// - Fifth-order noise shaper before each modulator.
// - Single-ended and bridge loads supported.
// - Headphone reuses modulators of channels 1, 2.
// - Headphone excludes power-stage drive.
// - Headphone chosen by dedicated select pin.
// - First-order dc-blocking high-pass per channel.
// - High-pass enable bit, default on.
// - Selectable de-emphasis via two-bit field.
// - Oversampling ratio follows detected sample rate.
// - Modulation limit programmable 93.8 to 99.2.
// - Supply-volume PWM output when enabled.
// - Supply-volume range -12, -18 or -24 dB.
// - AM avoidance shifts switching frequency.
// - Modulation limit resets to 97.7 percent.
`timescale 1ns/1ps
`default_nettype none
module omp_core import omp_pkg::*; #(
	parameter int CH = 8,
	parameter int SMP_W = 32
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic sample_valid_i,
	input wire logic [CH-1:0][SMP_W-1:0] sample_i,
	input wire logic [2:0] fs_code_i,
	input wire logic hp_sel_i,
	output logic [CH-1:0] pwm_p_o,
	output logic [CH-1:0] pwm_m_o,
	output logic [1:0] lineout_p_o,
	output logic [1:0] lineout_m_o,
	output logic [1:0] hp_p_o,
	output logic [1:0] hp_m_o,
	output logic supply_volume_pwm_o
);

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	logic [7:0] fsc_r, fsc_nxt, cfg_r, cfg_nxt, svl_r, svl_nxt, amt_r, amt_nxt, rd_nxt;
	logic [2:0] lim_r, lim_nxt;
	omp_mix_t mix_r, mix_nxt;
	logic mix_hit;
	logic [2:0] mo;
	logic [1:0] mt;

	// Address decode, read mux and register writes.
	always_comb begin
		mo = reg_addr_i[4:2];
		mt = reg_addr_i[1:0];
		mix_hit = (reg_addr_i[7:5] == OMP_MIX_PAGE) && (mt != 2'h3)
			&& ((mo >= 3'h6) || (mt != 2'h2));
		fsc_nxt = fsc_r;
		lim_nxt = lim_r;
		cfg_nxt = cfg_r;
		svl_nxt = svl_r;
		amt_nxt = amt_r;
		mix_nxt = mix_r;
		case (reg_addr_i)
			OMP_FSC_ADDR: rd_nxt = fsc_r;
			OMP_LIM_ADDR: rd_nxt = {5'h00, lim_r};
			OMP_CFG_ADDR: rd_nxt = cfg_r;
			OMP_SVL_ADDR: rd_nxt = svl_r;
			OMP_AMT_ADDR: rd_nxt = amt_r;
			default: rd_nxt = mix_hit ? mix_r[mo][mt] : 8'h00;
		endcase
		if (reg_wr_i) begin
			case (reg_addr_i)
				OMP_FSC_ADDR: fsc_nxt = reg_wdata_i;
				OMP_LIM_ADDR: lim_nxt = reg_wdata_i[2:0];
				OMP_CFG_ADDR: cfg_nxt = reg_wdata_i;
				OMP_SVL_ADDR: svl_nxt = reg_wdata_i;
				OMP_AMT_ADDR: amt_nxt = reg_wdata_i;
				default: begin
					if (mix_hit) begin
						mix_nxt[mo][mt] = reg_wdata_i;
					end
				end
			endcase
		end
	end

	// Register flops; high-pass on and limit code at 97.7 percent after reset.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			fsc_r <= OMP_FSC_RST;
			lim_r <= OMP_LIM_RST;
			cfg_r <= OMP_CFG_RST;
			svl_r <= OMP_SVL_RST;
			amt_r <= OMP_AMT_RST;
			mix_r <= omp_mix_rst();
			reg_rdata_o <= 8'h00;
		end else begin
			fsc_r <= fsc_nxt;
			lim_r <= lim_nxt;
			cfg_r <= cfg_nxt;
			svl_r <= svl_nxt;
			amt_r <= amt_nxt;
			mix_r <= mix_nxt;
			reg_rdata_o <= rd_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Headphone select synchroniser
	// ----------------------------------------------------------------
	logic hp_s1_r, hp_s2_r;

	// Two flops before the pin is used anywhere.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			hp_s1_r <= 1'b0;
			hp_s2_r <= 1'b0;
		end else begin
			hp_s1_r <= hp_sel_i;
			hp_s2_r <= hp_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// PWM frame timing and oversampling
	// ----------------------------------------------------------------
	logic [7:0] cnt_r, cnt_nxt, last_w, lim_w;
	logic [3:0] os_cnt_r, os_cnt_nxt, osr_w;
	logic [2:0] trim_w;
	logic frame_tick, sh_tick;

	// Frame counter; AM mode shortens the frame to move the carrier.
	always_comb begin
		trim_w = cfg_r[OMP_CFG_AM] ? (amt_r[2:0] ^ fs_code_i) : 3'h0;
		last_w = 8'hff - {5'h00, trim_w};
		lim_w = OMP_LIM_BASE + {4'h0, lim_r, 1'b0};
		osr_w = omp_osr(fs_code_i);
		frame_tick = (cnt_r == last_w);
		sh_tick = frame_tick && (os_cnt_r < osr_w);
		cnt_nxt = frame_tick ? 8'h00 : cnt_r + 8'h01;
		os_cnt_nxt = sample_valid_i ? 4'h0 : (sh_tick ? os_cnt_r + 4'h1 : os_cnt_r);
	end

	// Timing flops.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			cnt_r <= 8'h00;
			os_cnt_r <= 4'h0;
		end else begin
			cnt_r <= cnt_nxt;
			os_cnt_r <= os_cnt_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Per-channel mixer, filters and modulator
	// ----------------------------------------------------------------
	logic [SMP_W-1:0] filt_r [CH];
	wire logic [CH-1:0] chp, chm;

	for (genvar o = 0; o < CH; o++) begin : g_ch
		logic signed [39:0] hx1_r, hx1_nxt, hy1_r, hy1_nxt, lp_r, lp_nxt;
		logic signed [39:0] acc, hy, dx, sx, gx;
		logic [SMP_W-1:0] mixed, hpo, deo, filt_nxt;
		logic de_on;

		// Crossbar sum, dc-block and de-emphasis on each new sample.
		always_comb begin
			acc = '0;
			for (int t = 0; t < 3; t++) begin
				sx = 40'(signed'(sample_i[mix_r[o][t][7:5]]));
				gx = 40'(signed'({1'b0, mix_r[o][t][4:0]}));
				if ((t < 2) || (o >= 6)) begin
					acc = acc + sx * gx;
				end
			end
			mixed = cfg_r[OMP_CFG_PASS] ? sample_i[o] : omp_sat(acc >>> OMP_MIX_FRAC);
			hy = 40'(signed'(mixed)) - hx1_r + hy1_r - (hy1_r >>> OMP_HPF_SHIFT);
			hpo = fsc_r[OMP_HPF_BIT] ? omp_sat(hy) : mixed;
			de_on = (fsc_r[OMP_DE_LSB+1:OMP_DE_LSB] != 2'h0);
			dx = 40'(signed'(hpo)) - lp_r;
			deo = de_on ? omp_sat(lp_r + (dx >>> OMP_DE_SHELF)) : hpo;
			hx1_nxt = hx1_r;
			hy1_nxt = hy1_r;
			lp_nxt = lp_r;
			filt_nxt = filt_r[o];
			if (sample_valid_i) begin
				hx1_nxt = 40'(signed'(mixed));
				hy1_nxt = fsc_r[OMP_HPF_BIT] ? hy : 40'sd0;
				lp_nxt = de_on ? lp_r + (dx >>> omp_de_shift(fsc_r[1:0]))
					: 40'(signed'(hpo));
				filt_nxt = deo;
			end
		end

		// Filter state flops.
		always_ff @(posedge ref_clk_i) begin
			if (rst_i) begin
				hx1_r <= '0;
				hy1_r <= '0;
				lp_r <= '0;
				filt_r[o] <= '0;
			end else begin
				hx1_r <= hx1_nxt;
				hy1_r <= hy1_nxt;
				lp_r <= lp_nxt;
				filt_r[o] <= filt_nxt;
			end
		end

		omp_chan_mod #(
			.IN_W(16),
			.CNT_W(8)
		) u_mod (
			.ref_clk_i(ref_clk_i),
			.rst_i(rst_i),
			.tick_i(sh_tick),
			.sample_i(filt_r[o][SMP_W-1:SMP_W-16]),
			.lim_i(lim_w),
			.cnt_i(cnt_r),
			.last_i(last_w),
			.se_i(cfg_r[OMP_CFG_SE]),
			.p_o(chp[o]),
			.m_o(chm[o])
		);
	end

	// ----------------------------------------------------------------
	// Output steering
	// ----------------------------------------------------------------
	logic [CH-1:0] pp_nxt, pm_nxt;
	logic [1:0] lp_o_nxt, lm_o_nxt, hp_p_nxt, hp_m_nxt;
	logic [7:0] svc_duty;
	logic svc_nxt, six, lo_on;

	// Power drives idle in headphone mode; 7 and 8 move to line-out in six mode.
	always_comb begin
		six = cfg_r[OMP_CFG_SIX];
		lo_on = six && cfg_r[OMP_CFG_LO];
		for (int i = 0; i < CH; i++) begin
			pp_nxt[i] = !hp_s2_r && !(six && (i >= 6)) && chp[i];
			pm_nxt[i] = !hp_s2_r && !(six && (i >= 6)) && chm[i];
		end
		lp_o_nxt = lo_on ? chp[7:6] : 2'b00;
		lm_o_nxt = lo_on ? chm[7:6] : 2'b00;
		hp_p_nxt = hp_s2_r ? chp[1:0] : 2'b00;
		hp_m_nxt = hp_s2_r ? chm[1:0] : 2'b00;
		case (cfg_r[OMP_CFG_RNG+1:OMP_CFG_RNG])
			2'h0: svc_duty = 8'hff - (svl_r >> 2);
			2'h1: svc_duty = 8'hff - (svl_r >> 1);
			default: svc_duty = 8'hff - svl_r;
		endcase
		svc_nxt = cfg_r[OMP_CFG_SVC] && (cnt_r < svc_duty);
	end

	// Output flops.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pwm_p_o <= '0;
			pwm_m_o <= '0;
			lineout_p_o <= 2'b00;
			lineout_m_o <= 2'b00;
			hp_p_o <= 2'b00;
			hp_m_o <= 2'b00;
			supply_volume_pwm_o <= 1'b0;
		end else begin
			pwm_p_o <= pp_nxt;
			pwm_m_o <= pm_nxt;
			lineout_p_o <= lp_o_nxt;
			lineout_m_o <= lm_o_nxt;
			hp_p_o <= hp_p_nxt;
			hp_m_o <= hp_m_nxt;
			supply_volume_pwm_o <= svc_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_hp_excl;
		@(posedge ref_clk_i) disable iff (rst_i)
		hp_s2_r |=> (pwm_p_o == '0) && (pwm_m_o == '0);
	endproperty
	a_hp_excl: assert property (p_hp_excl) else $error("drive active in headphone");
	property p_hp_src;
		@(posedge ref_clk_i) disable iff (rst_i)
		hp_s2_r |=> (hp_p_o == $past(chp[1:0])) && (hp_m_o == $past(chm[1:0]));
	endproperty
	a_hp_src: assert property (p_hp_src) else $error("headphone source wrong");
	property p_hp_sync;
		@(posedge ref_clk_i) disable iff (rst_i)
		$rose(hp_sel_i) ##1 hp_sel_i |=> hp_s2_r;
	endproperty
	a_hp_sync: assert property (p_hp_sync) else $error("select pin not seen");
	property p_rst_val;
		@(posedge ref_clk_i) disable iff (rst_i)
		$fell(rst_i) |-> fsc_r[OMP_HPF_BIT] && (lim_w == 8'hfa);
	endproperty
	a_rst_val: assert property (p_rst_val) else $error("reset defaults wrong");
	property p_mix_wr;
		@(posedge ref_clk_i) disable iff (rst_i)
		reg_wr_i && (reg_addr_i == 8'h3a) ##1 (reg_addr_i == 8'h3a)
			|=> reg_rdata_o == $past(reg_wdata_i, 2);
	endproperty
	a_mix_wr: assert property (p_mix_wr) else $error("mixer gain not stored");
	property p_pass;
		@(posedge ref_clk_i) disable iff (rst_i)
		sample_valid_i && cfg_r[OMP_CFG_PASS] && !fsc_r[OMP_HPF_BIT] && (fsc_r[1:0] == 2'h0)
			|=> filt_r[3] == $past(sample_i[3]);
	endproperty
	a_pass: assert property (p_pass) else $error("pass-through altered data");
	property p_six;
		@(posedge ref_clk_i) disable iff (rst_i)
		six |=> (pwm_p_o[7:6] == 2'b00)
			&& (lineout_p_o == ($past(cfg_r[OMP_CFG_LO]) ? $past(chp[7:6]) : 2'b00));
	endproperty
	a_six: assert property (p_six) else $error("six-channel steering wrong");
	property p_svc_off;
		@(posedge ref_clk_i) disable iff (rst_i)
		!cfg_r[OMP_CFG_SVC] |=> !supply_volume_pwm_o;
	endproperty
	a_svc_off: assert property (p_svc_off) else $error("supply PWM while off");
	property p_osr;
		@(posedge ref_clk_i) disable iff (rst_i)
		$stable(fs_code_i) && ($past(os_cnt_r) <= $past(osr_w)) |-> os_cnt_r <= osr_w;
	endproperty
	a_osr: assert property (p_osr) else $error("too many shaper updates");

endmodule
`default_nettype wire

// *** dv/omp_stage_model.sv ***
// Behavioural model of the power stages that load the PWM outputs.
`timescale 1ns/1ps
`default_nettype none
module omp_stage_model (
	input wire logic ref_clk_i,
	input wire logic clr_i,
	input wire logic [7:0] p_i,
	output var logic [7:0][15:0] high_o,
	output var logic [8:0] max_o,
	output var logic [9:0] gap_o
);
	logic [7:0] p_r = 8'h00;
	logic [8:0] run_r = 9'h000;
	logic [9:0] age_r = 10'h000;

	// ----------------------------------------------------------------
	// Load integration and pulse timing
	// ----------------------------------------------------------------
	// Each stage integrates its drive; channel 1 also yields frame length and widest pulse.
	always @(posedge ref_clk_i) begin
		p_r <= p_i;
		age_r <= age_r + 10'h001;
		for (int c = 0; c < 8; c++) begin
			high_o[c] <= clr_i ? 16'h0000 : high_o[c] + 16'(p_i[c]);
		end
		if (p_i[0] && !p_r[0]) begin
			gap_o <= age_r;
			age_r <= 10'h001;
			run_r <= 9'h001;
		end else if (p_i[0]) begin
			run_r <= run_r + 9'h001;
		end
		if (clr_i) begin
			max_o <= 9'h000;
		end else if (!p_i[0] && p_r[0] && run_r > max_o) begin
			max_o <= run_r;
		end
	end
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking testbench of the output mixer and PWM modulator.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import omp_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic reg_wr_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [7:0] reg_rdata_o;
	logic sample_valid_i = 1'b0;
	logic [7:0][31:0] sample_i = '0;
	logic [2:0] fs_code_i = 3'h0;
	logic hp_sel_i = 1'b0;
	logic [7:0] pwm_p_o, pwm_m_o;
	logic [1:0] lineout_p_o, lineout_m_o, hp_p_o, hp_m_o;
	logic supply_volume_pwm_o;
	logic clr = 1'b1;
	logic [7:0] tick = 8'h00;
	logic [7:0][15:0] high;
	logic [8:0] mx;
	logic [9:0] gap;
	int bad_count = 0;
	int compares = 0;

	// ----------------------------------------------------------------
	// Clock, sample strobe and instances
	// ----------------------------------------------------------------
	// The clock toggles every half period of 20 ns.
	always #20 ref_clk_i = ~ref_clk_i;

	// A new sample set arrives once every 256 clocks, one frame apart.
	always @(negedge ref_clk_i) begin
		tick <= tick + 8'h01;
		sample_valid_i <= (tick == 8'h00) && !rst_i;
	end

	omp_core dut_u (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.sample_valid_i(sample_valid_i), .sample_i(sample_i), .fs_code_i(fs_code_i),
		.hp_sel_i(hp_sel_i), .pwm_p_o(pwm_p_o), .pwm_m_o(pwm_m_o),
		.lineout_p_o(lineout_p_o), .lineout_m_o(lineout_m_o), .hp_p_o(hp_p_o),
		.hp_m_o(hp_m_o), .supply_volume_pwm_o(supply_volume_pwm_o)
	);

	omp_stage_model stage_u (
		.ref_clk_i(ref_clk_i), .clr_i(clr), .p_i(pwm_p_o),
		.high_o(high), .max_o(mx), .gap_o(gap)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	// Compare a seen value with the expected one and count both outcomes.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Print the counts and the verdict, then stop.
	task automatic final_report();
		$display("bad_count %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// One write: strobe held for exactly one rising edge.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk_i);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(negedge ref_clk_i);
		reg_wr_i = 1'b0;
	endtask

	// Read one register, answer one cycle after the address, and compare it.
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		@(negedge ref_clk_i);
		reg_addr_i = a;
		@(negedge ref_clk_i);
		check(reg_rdata_o, exp);
	endtask

	// Let the output settle, then integrate every channel over eight frames.
	task automatic avg(output logic [7:0][15:0] h);
		repeat (512) @(negedge ref_clk_i);
		clr = 1'b1;
		@(negedge ref_clk_i);
		clr = 1'b0;
		repeat (2048) @(negedge ref_clk_i);
		h = high;
	endtask

	// Collect which outputs moved, and the supply-volume high time.
	task automatic obs(input int n, output logic [20:0] a, output int s);
		a = '0;
		s = 0;
		repeat (n) begin
			@(negedge ref_clk_i);
			a |= {supply_volume_pwm_o, lineout_p_o | lineout_m_o, hp_p_o | hp_m_o, pwm_m_o, pwm_p_o};
			s += int'(supply_volume_pwm_o);
		end
	endtask

	// Spread the channels from half negative to well positive.
	task automatic ramp();
		for (int k = 0; k < 8; k++) begin
			sample_i[k] = 32'(k - 4) * 32'h10000000;
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Reset values, the mixer map and refused addresses.
	task automatic t_reset_map();
		rc(OMP_FSC_ADDR, OMP_FSC_RST);
		rc(OMP_LIM_ADDR, {5'h00, OMP_LIM_RST});
		rc(OMP_CFG_ADDR, OMP_CFG_RST);
		for (int o = 0; o < 8; o++) begin
			rc(8'h20 + 8'(4 * o), {3'(o), OMP_MIX_UNITY});
			rc(8'h22 + 8'(4 * o), 8'h00);
		end
		wr(8'h3f, 8'hff);
		rc(8'h3f, 8'h00);
	endtask

	// Field write-back: de-emphasis codes, filter enable, limit codes, mixer entry.
	task automatic t_regs();
		for (int d = 0; d < 4; d++) begin
			wr(OMP_FSC_ADDR, 8'h80 | 8'(d));
			rc(OMP_FSC_ADDR, 8'h80 | 8'(d));
		end
		wr(OMP_FSC_ADDR, 8'h00);
		rc(OMP_FSC_ADDR, 8'h00);
		for (int c = 0; c < 8; c++) begin
			wr(OMP_LIM_ADDR, 8'(c));
			rc(OMP_LIM_ADDR, 8'(c));
		end
		wr(8'h3a, 8'he8);
		rc(8'h3a, 8'he8);
		wr(8'h3a, 8'h00);
	endtask

	// Remapping without any channel mute; filters are off so levels hold.
	task automatic t_mix();
		logic [7:0][15:0] h;
		ramp();
		avg(h);
		for (int k = 1; k < 8; k++) begin
			check(32'(h[k] > h[k-1]), 1);
		end
		wr(8'h20, 8'hf0);
		avg(h);
		check(32'((h[0] > h[7] ? h[0] - h[7] : h[7] - h[0]) < 16'd64), 1);
		wr(OMP_CFG_ADDR, 8'h01);
		avg(h);
		check(32'(h[0] < h[1]), 1);
		wr(OMP_CFG_ADDR, 8'h00);
		wr(8'h20, 8'h10);
	endtask

	// Full-scale input must be clamped at 240 plus twice the limit code.
	task automatic t_limit();
		int codes[3] = '{0, 5, 7};
		sample_i = {8{32'h7fffffff}};
		foreach (codes[i]) begin
			wr(OMP_LIM_ADDR, 8'(codes[i]));
			repeat (512) @(negedge ref_clk_i);
			clr = 1'b1;
			@(negedge ref_clk_i);
			clr = 1'b0;
			repeat (1024) @(negedge ref_clk_i);
			check(mx, 32'(240 + 2 * codes[i]));
		end
		wr(OMP_LIM_ADDR, 8'h05);
		ramp();
	endtask

	// Single-ended loads take the minus leg as the inverse of the plus leg.
	task automatic t_load();
		logic [7:0] x;
		wr(OMP_CFG_ADDR, 8'h04);
		repeat (8) @(negedge ref_clk_i);
		x = 8'hff;
		repeat (600) begin
			@(negedge ref_clk_i);
			x &= pwm_p_o ^ pwm_m_o;
		end
		check(x, 8'hff);
		wr(OMP_CFG_ADDR, 8'h00);
	endtask

	// Output configurations, headphone select and supply-volume ranges.
	task automatic t_modes();
		logic [20:0] a;
		int s[3];
		obs(600, a, s[0]);
		check(a, 21'h00ffff);
		wr(OMP_CFG_ADDR, 8'h02);
		obs(600, a, s[0]);
		check(a, 21'h003f3f);
		wr(OMP_CFG_ADDR, 8'h82);
		obs(600, a, s[0]);
		check(a, 21'h0c3f3f);
		wr(OMP_CFG_ADDR, 8'h00);
		hp_sel_i = 1'b1;
		repeat (8) @(negedge ref_clk_i);
		obs(600, a, s[0]);
		check(a, 21'h030000);
		hp_sel_i = 1'b0;
		repeat (8) @(negedge ref_clk_i);
		// Only the supply level is set; each range is then enabled in turn.
		wr(OMP_SVL_ADDR, 8'h80);
		for (int r = 0; r < 3; r++) begin
			wr(OMP_CFG_ADDR, 8'h08 | 8'(r << 4));
			obs(1024, a, s[r]);
			check(a[20], 1);
		end
		check(32'(s[0] != s[1] && s[1] != s[2] && s[0] != s[2]), 1);
		check(s[0], 32'd892);
		check(s[2], 32'd508);
		wr(OMP_CFG_ADDR, 8'h00);
		wr(OMP_SVL_ADDR, 8'h00);
	endtask

	// AM avoidance shortens the frame by the tuned code against the rate code.
	task automatic t_am();
		repeat (768) @(negedge ref_clk_i);
		check(gap, 32'd256);
		wr(OMP_AMT_ADDR, 8'h03);
		wr(OMP_CFG_ADDR, 8'h40);
		repeat (768) @(negedge ref_clk_i);
		check(gap, 32'd253);
		fs_code_i = 3'h5;
		repeat (768) @(negedge ref_clk_i);
		check(gap, 32'd250);
		wr(OMP_CFG_ADDR, 8'h00);
		fs_code_i = 3'h0;
	endtask

	// ----------------------------------------------------------------
	// Main sequence and hang guard
	// ----------------------------------------------------------------
	// Reset for 16 clocks with outputs quiet, then run every scenario.
	initial begin
		repeat (16) @(negedge ref_clk_i);
		check(32'({pwm_p_o, pwm_m_o, lineout_p_o | lineout_m_o, hp_p_o | hp_m_o}), 0);
		rst_i = 1'b0;
		t_reset_map();
		t_regs();
		t_mix();
		t_limit();
		t_load();
		t_modes();
		t_am();
		final_report();
	end

	// A run that outlasts its cycle budget is counted as a mismatch.
	initial begin
		repeat (100000) @(posedge ref_clk_i);
		bad_count++;
		final_report();
	end
endmodule
`default_nettype wire
